// File: logic/pasm_regs.vh
// Constants of the auxiliary status and mode register bank: offsets, field positions and reset values.
// Assumes it is included by its bare name from the design files of this bank.
`ifndef PASM_REGS_VH
`define PASM_REGS_VH

// Register indexes as printed, and byte addresses on the 32-bit register bus.
`define PASM_IDX_ERR_STATUS   8'h1c
`define PASM_IDX_AUX_MODE     8'h1d
`define PASM_ADDR_ERR_STATUS  8'h70
`define PASM_ADDR_AUX_MODE    8'h74
`define PASM_ADDR_PHY_CTRL    8'h78
`define PASM_ADDR_IRQ_STATUS  8'h80
`define PASM_ADDR_IRQ_CLEAR   8'h84
`define PASM_ADDR_IRQ_ENABLE  8'h88

// Error and general status fields.
`define PASM_ST_CODE_ERR      10
`define PASM_ST_EOF_ERR       9
`define PASM_ST_POLARITY      8
`define PASM_ST_REV_HI        7
`define PASM_ST_REV_LO        5
`define PASM_ST_AN_ENABLED    3
`define PASM_ST_FORCE_100     2
`define PASM_ST_SPEED_100     1
`define PASM_ST_FULL_DUPLEX   0

// Auxiliary mode fields and reset value.
`define PASM_MD_PHY_CONNECT   13
`define PASM_MD_ACT_LED_OFF   4
`define PASM_MD_LINK_LED_OFF  3
`define PASM_MD_IPG_SMOOTH    1
`define PASM_MD_WMASK         16'h201a
`define PASM_MD_RESET         16'h0000

// Shadow of the management control bits that steer negotiation and forced speed.
`define PASM_CT_AN_ENABLE     12
`define PASM_CT_SPEED_100     13
`define PASM_CT_WMASK         16'h3000
`define PASM_CT_RESET         16'h3000

// Interrupt event bits.
`define PASM_IRQ_WIDTH        3
`define PASM_IRQ_CODE_ERR     0
`define PASM_IRQ_EOF_ERR      1
`define PASM_IRQ_POL_CHANGE   2

// Inter-packet gap smoothing figures, in transmit symbol periods.
`define PASM_IPG_SHORT_MIN    3'h1
`define PASM_IPG_SHORT_MAX    3'h4
`define PASM_IPG_SAT          3'h5

// AXI response codes.
`define PASM_RESP_OKAY        2'h0
`define PASM_RESP_SLVERR      2'h2

`endif

// File: logic/pasm_ipg_smoother.v
// Transmit gap smoother: stretches a short inter-packet gap by two idle symbols.
// Assumes transmit data and enable are on aclk and advance on the symbol enable pulse.
`timescale 1ns/100ps
`default_nettype none
`include "pasm_regs.vh"

module pasm_ipg_smoother #(
  parameter DATA_W = 2
) (
  // Clock and reset.
  input  wire              aclk,
  input  wire              aresetn,
  // Control.
  input  wire              smooth_enable,
  input  wire              symbol_strobe,
  // Transmit stream from the controller.
  input  wire              tx_en_in,
  input  wire [DATA_W-1:0] txd_in,
  // Transmit stream toward the encoder.
  output reg               tx_en_out,
  output reg  [DATA_W-1:0] txd_out
);

  reg  [2:0]        gap_q;
  reg               delay_q;
  reg  [1:0]        sh_en_q;
  reg  [DATA_W-1:0] sh_d0_q;
  reg  [DATA_W-1:0] sh_d1_q;
  wire              start_w;
  wire              short_w;
  reg               delay_d;

  // A packet starts at its first enabled symbol; a gap of one to four idle symbols is short.
  assign start_w = tx_en_in & ~sh_en_q[0];
  assign short_w = (gap_q >= `PASM_IPG_SHORT_MIN) & (gap_q <= `PASM_IPG_SHORT_MAX);

  // The delayed path is taken at a short gap and left once the pipe has drained.
  always @*
  begin
    delay_d = delay_q;
    if (start_w & short_w & smooth_enable)
      delay_d = 1'b1;
    else if (~tx_en_in & ~sh_en_q[0] & ~sh_en_q[1])
      delay_d = 1'b0;
  end

  // Gap counter, two-symbol pipe and output select, all stepped per symbol.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_q     <= 3'h0;
      delay_q   <= 1'b0;
      sh_en_q   <= 2'h0;
      sh_d0_q   <= {DATA_W{1'b0}};
      sh_d1_q   <= {DATA_W{1'b0}};
      tx_en_out <= 1'b0;
      txd_out   <= {DATA_W{1'b0}};
    end
    else if (symbol_strobe)
    begin
      if (tx_en_in)
        gap_q <= 3'h0;
      else if (gap_q != `PASM_IPG_SAT)
        gap_q <= gap_q + 3'h1;
      delay_q <= delay_d;
      sh_en_q <= {sh_en_q[0], tx_en_in};
      sh_d0_q <= txd_in;
      sh_d1_q <= sh_d0_q;
      // Two-symbol-old data on the delayed path yields two inserted idles.
      if (delay_d)
      begin
        tx_en_out <= sh_en_q[1];
        txd_out   <= sh_d1_q;
      end
      else
      begin
        tx_en_out <= tx_en_in;
        txd_out   <= txd_in;
      end
    end
  end

endmodule
`default_nettype wire

// File: logic/pasm_regs_top.v
// Auxiliary error/general status and auxiliary mode registers of one transceiver port, on AXI4-Lite.
// Assumes the receive decoder, polarity detector and LED sources run on aclk; strap pins are asynchronous.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "pasm_regs.vh"

module pasm_regs_top #(
  parameter       DATA_W   = 2,
  parameter [2:0] REVISION = 3'h2 // Arbitrary value.
) (
  // Clock and reset.
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address channel.
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response channel.
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data channel.
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Strap pins, asynchronous.
  input  wire              negotiation_enable_pin,
  input  wire              forced_speed_select_pin,
  // Receive-side events and line state from the port logic.
  input  wire              code_violation_event,
  input  wire              frame_end_error_event,
  input  wire              polarity_inverted,
  input  wire              speed_is_100,
  input  wire              negotiation_in_progress,
  input  wire              full_duplex_active,
  // Segmentation setting from the shared configuration.
  input  wire              segmentation_enable,
  // LED sources, active high.
  input  wire              activity_led_src,
  input  wire              link_led_src,
  // Transmit stream.
  input  wire              transmit_symbol_clock,
  input  wire              tx_en_in,
  input  wire [DATA_W-1:0] txd_in,
  output wire              tx_en_out,
  output wire [DATA_W-1:0] txd_out,
  // Port outputs.
  output wire              rx_error,
  output reg               rmii_connect,
  output reg               activity_led_n,
  output reg               link_led_n,
  output wire              irq
);

  reg         an_pin_s1_q;
  reg         an_pin_s2_q;
  reg         fs_pin_s1_q;
  reg         fs_pin_s2_q;
  reg         code_err_q;
  reg         eof_err_q;
  reg         pol_prev_q;
  reg  [15:0] mode_q;
  reg  [15:0] ctrl_q;
  reg  [2:0]  irq_st_q;
  reg  [2:0]  irq_en_q;
  reg         aw_hold_q;
  reg  [7:0]  aw_addr_q;
  reg         w_hold_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  wire        do_write;
  wire        do_read;
  wire [15:0] status_w;
  wire [15:0] wmask_w;
  wire [2:0]  irq_event_w;
  wire        an_enabled_w;
  wire        speed_forced_10_w;
  reg  [31:0] rdata_d;
  reg  [1:0]  rresp_d;
  reg         clr_err_d;
  reg  [2:0]  irq_clr_d;

  // Strap pins pass two flip-flops before any logic reads them.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      an_pin_s1_q <= 1'b0;
      an_pin_s2_q <= 1'b0;
      fs_pin_s1_q <= 1'b0;
      fs_pin_s2_q <= 1'b0;
    end
    else
    begin
      an_pin_s1_q <= negotiation_enable_pin;
      an_pin_s2_q <= an_pin_s1_q;
      fs_pin_s1_q <= forced_speed_select_pin;
      fs_pin_s2_q <= fs_pin_s1_q;
    end
  end

  // Negotiation and forced-speed indications derived from pins and control bits.
  assign an_enabled_w      = ctrl_q[`PASM_CT_AN_ENABLE] & an_pin_s2_q;
  assign speed_forced_10_w = (~an_pin_s2_q & ~fs_pin_s2_q) |
                             (~ctrl_q[`PASM_CT_AN_ENABLE] & ~ctrl_q[`PASM_CT_SPEED_100]);

  // Status word as software reads it; reserved bits read zero.
  assign status_w = {5'h00,
                     code_err_q,
                     eof_err_q,
                     polarity_inverted,
                     REVISION,
                     1'b0,
                     an_enabled_w,
                     ~speed_forced_10_w,
                     speed_is_100 & ~negotiation_in_progress,
                     full_duplex_active};

  // Error events reach the controller in the cycle they occur; polarity inversion never does.
  assign rx_error = code_violation_event | frame_end_error_event;

  // Latched-high error flags; an event in the clearing cycle wins over the clear.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      code_err_q <= 1'b0;
      eof_err_q  <= 1'b0;
    end
    else
    begin
      code_err_q <= (code_err_q & ~clr_err_d) | code_violation_event;
      eof_err_q  <= (eof_err_q & ~clr_err_d) | frame_end_error_event;
    end
  end

  // Interrupt events: the two errors and a change of receive polarity.
  assign irq_event_w[`PASM_IRQ_CODE_ERR]   = code_violation_event;
  assign irq_event_w[`PASM_IRQ_EOF_ERR]    = frame_end_error_event;
  assign irq_event_w[`PASM_IRQ_POL_CHANGE] = polarity_inverted ^ pol_prev_q;

  // Sticky interrupt status with set over clear, and its level output.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_st_q   <= 3'h0;
      pol_prev_q <= 1'b0;
    end
    else
    begin
      irq_st_q   <= (irq_st_q & ~irq_clr_d) | irq_event_w;
      pol_prev_q <= polarity_inverted;
    end
  end

  assign irq = |(irq_st_q & irq_en_q);

  // Write address and data are taken independently and held until the write is done.
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign do_write      = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  // Read address is taken only while no read answer is pending.
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read       = s_axi_arvalid & s_axi_arready;

  // Byte lanes 0 and 1 carry the 16-bit registers.
  assign wmask_w = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Read decode; a status read also requests clearing its latched flags.
  always @*
  begin
    rdata_d   = 32'h0000_0000;
    rresp_d   = `PASM_RESP_OKAY;
    clr_err_d = 1'b0;
    case (s_axi_araddr)
      `PASM_ADDR_ERR_STATUS:
      begin
        rdata_d   = {16'h0000, status_w};
        clr_err_d = do_read;
      end
      `PASM_ADDR_AUX_MODE:   rdata_d = {16'h0000, mode_q};
      `PASM_ADDR_PHY_CTRL:   rdata_d = {16'h0000, ctrl_q};
      `PASM_ADDR_IRQ_STATUS: rdata_d = {29'h0000_0000, irq_st_q};
      `PASM_ADDR_IRQ_CLEAR:  rdata_d = 32'h0000_0000;
      `PASM_ADDR_IRQ_ENABLE: rdata_d = {29'h0000_0000, irq_en_q};
      default:               rresp_d = `PASM_RESP_SLVERR;
    endcase
  end

  // Write-one-to-clear strobe for the interrupt status.
  always @*
  begin
    irq_clr_d = 3'h0;
    if (do_write && (aw_addr_q == `PASM_ADDR_IRQ_CLEAR) && w_strb_q[0])
      irq_clr_d = w_data_q[2:0];
  end

  // Write channel handshakes, register updates and response.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_hold_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PASM_RESP_OKAY;
      mode_q       <= `PASM_MD_RESET;
      ctrl_q       <= `PASM_CT_RESET;
      irq_en_q     <= 3'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PASM_RESP_OKAY;
        case (aw_addr_q)
          // Only the defined mode bits are writable; the revision has no write path.
          `PASM_ADDR_AUX_MODE:
            mode_q <= (mode_q & ~(wmask_w & `PASM_MD_WMASK)) |
                      (w_data_q[15:0] & wmask_w & `PASM_MD_WMASK);
          `PASM_ADDR_PHY_CTRL:
            ctrl_q <= (ctrl_q & ~(wmask_w & `PASM_CT_WMASK)) |
                      (w_data_q[15:0] & wmask_w & `PASM_CT_WMASK);
          `PASM_ADDR_IRQ_ENABLE:
            if (w_strb_q[0])
              irq_en_q <= w_data_q[2:0];
          `PASM_ADDR_ERR_STATUS:  s_axi_bresp <= `PASM_RESP_OKAY;
          `PASM_ADDR_IRQ_STATUS:  s_axi_bresp <= `PASM_RESP_OKAY;
          `PASM_ADDR_IRQ_CLEAR:   s_axi_bresp <= `PASM_RESP_OKAY;
          default:                s_axi_bresp <= `PASM_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer is captured at the address handshake, before the flags clear.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PASM_RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rresp_d;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Port connection and LED drive; a disabled LED stays dark (high).
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rmii_connect   <= 1'b1;
      activity_led_n <= 1'b1;
      link_led_n     <= 1'b1;
    end
    else
    begin
      rmii_connect   <= segmentation_enable ? mode_q[`PASM_MD_PHY_CONNECT] : 1'b1;
      activity_led_n <= ~(activity_led_src & ~mode_q[`PASM_MD_ACT_LED_OFF]);
      link_led_n     <= ~(link_led_src & ~mode_q[`PASM_MD_LINK_LED_OFF]);
    end
  end

  // Transmit path through the gap smoother.
  pasm_ipg_smoother #(
    .DATA_W (DATA_W)
  ) u_smoother (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .smooth_enable (mode_q[`PASM_MD_IPG_SMOOTH]),
    .symbol_strobe (transmit_symbol_clock),
    .tx_en_in      (tx_en_in),
    .txd_in        (txd_in),
    .tx_en_out     (tx_en_out),
    .txd_out       (txd_out)
  );

endmodule
`default_nettype wire

// File: verif/pasm_regs_chk.sv
// Checker for the auxiliary status and mode register bank, watching top-level ports only.
// Assumes one clock domain, aclk, with aresetn as its synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module pasm_regs_chk (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Receive events and line state.
  input wire logic        code_violation_event,
  input wire logic        frame_end_error_event,
  input wire logic        polarity_inverted,
  input wire logic        rx_error,
  // Port outputs and their sources.
  input wire logic        segmentation_enable,
  input wire logic        rmii_connect,
  input wire logic        activity_led_src,
  input wire logic        link_led_src,
  input wire logic        activity_led_n,
  input wire logic        link_led_n,
  input wire logic        irq
);
  // All properties run on the bus clock and are idle during reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RX_ERR_SAME_CYCLE: assert property (rx_error == (code_violation_event | frame_end_error_event))
    else $error("receive error does not follow the error events");
  AST_POL_NO_ERR: assert property ($changed(polarity_inverted) && !code_violation_event && !frame_end_error_event
    |-> !rx_error)
    else $error("polarity change raised a receive error");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data did not follow the read address");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before it was taken");
  AST_SEG_OFF: assert property (!segmentation_enable |=> rmii_connect)
    else $error("port disconnected while segmentation is off");
  AST_ACT_IDLE: assert property ((!activity_led_src) [*2] |-> activity_led_n)
    else $error("activity LED lit without a request");
  AST_LINK_IDLE: assert property (!link_led_src |=> link_led_n)
    else $error("link LED lit without a request");

  // Main scenarios reached.
  cover property (code_violation_event && rx_error);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (irq);
endmodule

bind pasm_regs_top pasm_regs_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .code_violation_event(code_violation_event),
  .frame_end_error_event(frame_end_error_event), .polarity_inverted(polarity_inverted), .rx_error(rx_error),
  .segmentation_enable(segmentation_enable), .rmii_connect(rmii_connect), .activity_led_src(activity_led_src),
  .link_led_src(link_led_src), .activity_led_n(activity_led_n), .link_led_n(link_led_n), .irq(irq)
);
`default_nettype wire

// File: verif/pasm_host_model.sv
// Management software model: issues single AXI4-Lite writes and reads, promptly or slowly.
// Assumes it shares aclk with the register bank and that one task runs at a time.
`timescale 1ns/100ps
`default_nettype none

module pasm_host_model (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       s_axi_awaddr = 8'h0,
  output logic             s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata = 32'h0,
  output logic [3:0]       s_axi_wstrb = 4'h0,
  output logic             s_axi_wvalid = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready = 1'b0,
  // Read channels.
  output logic [7:0]       s_axi_araddr = 8'h0,
  output logic             s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready = 1'b0
);
  // When set, the response ready is raised only after the answer is already waiting.
  bit slow = 1'b0;

  // One write: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    for (int n = 0; n < 50 && !ok; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        ok = 1;
      end
      else if (n == 3)
        s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
  endtask

  // One read: data and response taken at the edge where valid and ready meet.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    for (int n = 0; n < 50 && !ok; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        ok = 1;
      end
      else if (n == 2)
        s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/pasm_regs_tb_top.sv
// Self-checking bench for the auxiliary status and mode register bank.
// Assumes the host model in pasm_host_model.sv and the bound checker.
`timescale 1ns/100ps
`default_nettype none

module pasm_regs_tb_top;
  localparam logic [2:0] REV = 3'h5; // Arbitrary value.
  logic        aclk, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, txd_out, txd_in = 2'h0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        negotiation_enable_pin = 1, forced_speed_select_pin = 1, code_violation_event = 0;
  logic        frame_end_error_event = 0, polarity_inverted = 0, speed_is_100 = 1, negotiation_in_progress = 0;
  logic        full_duplex_active = 1, segmentation_enable = 0, activity_led_src = 1, link_led_src = 1;
  logic        transmit_symbol_clock = 1, tx_en_in = 0, tx_en_out;
  logic        rx_error, rmii_connect, activity_led_n, link_led_n, irq;
  int          n_fail = 0, num_checks = 0, g;

  pasm_regs_top #(.DATA_W(2), .REVISION(REV)) u_dut (.*);
  pasm_host_model u_host (.*);

  // 40 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A bus wait that ran out ends the run.
  task automatic tmo(input bit ok);
    if (!ok)
    begin
      n_fail++;
      test_done();
    end
  endtask

  // Register write and read with response and data compared.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit ok;
    u_host.wr(a, d, r, ok);
    tmo(ok);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    u_host.rd(a, d, r, ok);
    tmo(ok);
    chk("rresp", {30'h0, r}, {30'h0, er});
    if (er == 2'h0)
      chk("rdata", d, e);
  endtask

  // One-cycle error event; 0 is a code violation, 1 an end-of-frame error.
  task automatic pulse(input int i);
    @(posedge aclk);
    code_violation_event <= (i == 0);
    frame_end_error_event <= (i == 1);
    #1 chk("rx_error", {31'h0, rx_error}, 32'h1);
    @(posedge aclk);
    code_violation_event <= 1'b0;
    frame_end_error_event <= 1'b0;
  endtask

  // Sends two frames three symbols long with a two-symbol gap; returns the gap seen at the output.
  task automatic tx_run(output int gap);
    logic [21:0] pat = 22'b0000000011100111000000;
    int first = -1, last = 0, ones = 0;
    for (int k = 0; k < 30; k++)
    begin
      @(posedge aclk);
      tx_en_in <= (k < 22) ? pat[k] : 1'b0;
      txd_in <= (k < 22 && pat[k]) ? 2'h3 : 2'h0;
      chk("txd", {30'h0, txd_out}, {30'h0, {2{tx_en_out}}});
      if (tx_en_out === 1'b1)
      begin
        if (first < 0)
          first = k;
        last = k;
        ones++;
      end
    end
    gap = last - first + 1 - ones;
  endtask

  // Expected status word from error, polarity and indication bits.
  function automatic logic [31:0] st(input logic [2:0] f, input logic [3:0] lo);
    return {21'h0, f, REV, 1'b0, lo};
  endfunction

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rreg(8'h74, 32'h0, 2'h0);
    wreg(8'h70, 32'hffff, 2'h0);
    rreg(8'h70, st(3'h0, 4'hf), 2'h0);
    for (int i = 0; i < 2; i++)
    begin
      pulse(i);
      rreg(8'h70, st(3'h4 >> i, 4'hf), 2'h0);
      rreg(8'h70, st(3'h0, 4'hf), 2'h0);
    end
    // Interrupt raised, masked, unmasked and cleared.
    wreg(8'h84, 32'h7, 2'h0);
    wreg(8'h88, 32'h7, 2'h0);
    pulse(0);
    #1 chk("irq", {31'h0, irq}, 32'h1);
    rreg(8'h80, 32'h1, 2'h0);
    wreg(8'h88, 32'h0, 2'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wreg(8'h88, 32'h1, 2'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    wreg(8'h84, 32'h1, 2'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    rreg(8'h84, 32'h0, 2'h0);
    rreg(8'h70, st(3'h4, 4'hf), 2'h0);
    // Indications over every pin combination, with both control bits clear and then both set.
    for (int i = 0; i < 8; i++)
    begin
      wreg(8'h78, i[2] ? 32'h3000 : 32'h0, 2'h0);
      negotiation_enable_pin <= i[0];
      forced_speed_select_pin <= i[1];
      negotiation_in_progress <= i[1];
      speed_is_100 <= !i[2];
      full_duplex_active <= i[0];
      polarity_inverted <= i[2];
      repeat (3) @(posedge aclk);
      rreg(8'h70, st({2'h0, i[2]}, {i[2] & i[0], !((!i[0] && !i[1]) || !i[2]), !i[1] && !i[2], i[0]}),
           2'h0);
    end
    // Only the polarity change is left pending in the interrupt status.
    rreg(8'h80, 32'h4, 2'h0);
    // Mode bits: storage, LEDs, port connection, idle LED sources.
    segmentation_enable <= 1'b1;
    wreg(8'h74, 32'hffff, 2'h0);
    rreg(8'h74, 32'h201a, 2'h0);
    #1 chk("outs", {activity_led_n, link_led_n, rmii_connect}, 3'h7);
    wreg(8'h74, 32'h0, 2'h0);
    #1 chk("outs", {activity_led_n, link_led_n, rmii_connect}, 3'h0);
    activity_led_src <= 1'b0;
    link_led_src <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 chk("leds", {activity_led_n, link_led_n}, 2'h3);
    activity_led_src <= 1'b1;
    link_led_src <= 1'b1;
    // Unmapped place, with a slow host.
    u_host.slow = 1'b1;
    wreg(8'hfc, 32'h1, 2'h2);
    rreg(8'hfc, 32'h0, 2'h2);
    u_host.slow = 1'b0;
    // Gap smoothing off, then on.
    for (int m = 0; m < 2; m++)
    begin
      wreg(8'h74, m ? 32'h2 : 32'h0, 2'h0);
      tx_run(g);
      chk("gap", g, m ? 4 : 2);
    end
    test_done();
  end
endmodule
`default_nettype wire
